//--- hw/pmcfg_pkg.sv
// Package: offsets, field positions and reset values of the power-management config registers
package pmcfg_pkg;
   // Configuration-space byte offsets (dword aligned access, byte enables select lanes)
   localparam logic [7:0]  CTLSTS_OFFSET     = 8'h48;   // control/status, bytes 0-1 of dword 48h
   localparam logic [7:0]  PMEXT_OFFSET      = 8'h4A;   // extension, bytes 2-3 of dword 48h
   localparam logic [7:0]  MISC_OFFSET       = 8'hF0;
   localparam logic [7:0]  PM_DWORD_OFFSET   = 8'h48;
   // Control/status field positions
   localparam int          WAKE_STATUS_BIT   = 15;
   localparam int          WAKE_ENABLE_BIT   = 8;
   localparam int          DYN_INFO_BIT      = 4;
   localparam int          PSTATE_LSB        = 0;
   localparam logic [15:0] CTLSTS_RESET      = 16'h0000;
   localparam logic [15:0] PMEXT_VALUE       = 16'h0000;
   localparam logic [7:0]  PM_INFO_BYTE      = 8'h00;
   localparam logic [7:0]  BRIDGE_EXT_BYTE   = 8'h00;
   // Miscellaneous configuration layout
   localparam logic [31:0] MISC_RESET        = 32'h0000_2400;
   localparam logic [31:0] MISC_WRITE_MASK   = 32'h0000_A41F;
   localparam logic [4:0]  WAKE_CAPS_NONE    = 5'h00;
   // Power state encodings
   typedef enum logic [1:0] {
      PMCFG_D0     = 2'h0,
      PMCFG_D1     = 2'h1,
      PMCFG_D2     = 2'h2,
      PMCFG_D3HOT  = 2'h3
   } pmcfg_pstate_e;
endpackage

//--- hw/pmcfg_wake_ctl.sv
// Wake status flag, wake enable and wake output for the power-management block
`timescale 1ns/1ps
module pmcfg_wake_ctl #(
   parameter bit COLD_WAKE = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic hotReset,
   input  wire logic wakeEvent,
   input  wire logic enWrite,
   input  wire logic enData,
   input  wire logic stsClear,
   input  wire logic enAllowed,
   output logic      wakeStatus,
   output logic      wakeEnable,
   output logic      wakeOut
);
   typedef struct packed {
      logic sts;
      logic en;
      logic out;
   } pmcfg_wake_s;

   pmcfg_wake_s st_q;
   pmcfg_wake_s st_d;

   // Next state of the wake flag, enable and pin
   always_comb begin
      st_d = st_q;
      if (wakeEvent) begin
         st_d.sts = 1'b1;
      end else if (stsClear) begin
         st_d.sts = 1'b0;
      end
      if (!enAllowed) begin
         st_d.en = 1'b0;
      end else if (enWrite) begin
         st_d.en = enData;
      end
      st_d.out = st_d.sts & st_d.en;
   end

   // Sticky bits survive the D3hot exit reset; enable survives srst with cold wake
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q.sts <= 1'b0;
         st_q.en  <= COLD_WAKE ? st_q.en : 1'b0;   // Sticky copy ignores writes during reset
         st_q.out <= 1'b0;
      end else begin
         // internal hot reset leaves state intact
         st_q <= st_d;
      end
   end

   assign wakeStatus = st_q.sts;
   assign wakeEnable = st_q.en;
   assign wakeOut    = st_q.out;
endmodule // pmcfg_wake_ctl

//--- hw/pmcfg_regs.sv
// Power-management configuration registers: control/status, extension, misc configuration
`timescale 1ns/1ps
module pmcfg_regs #(
   parameter bit COLD_WAKE = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        hotReset,
   input  wire logic        cfgRead,
   input  wire logic        cfgWrite,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgWrData,
   input  wire logic        wakeEvent,
   input  wire logic [4:0]  wakeCaps,
   output logic [31:0]      cfgRdData,
   output logic             cfgRdValid,
   output logic [1:0]       powerState,
   output logic [31:0]      miscConfig,
   output logic             wakeOut
);
   typedef struct packed {
      logic [31:0] rdData;
      logic        rdValid;
      logic [1:0]  pstate;
      logic [31:0] misc;
   } pmcfg_regs_s;

   pmcfg_regs_s st_q;
   pmcfg_regs_s st_d;

   logic        pmHit;
   logic        miscHit;
   logic        enWrite;
   logic        stsClear;
   logic        enAllowed;
   logic        wakeStatus;
   logic        wakeEnable;
   logic [15:0] ctlStsView;
   logic [15:0] extView;
   logic [31:0] pmDword;
   logic [31:0] rdWord;
   logic [31:0] miscWrite;
   logic [3:0]  miscLaneWr;
   logic [1:0]  newState;
   logic        pstateLegal;
   logic        ctlLane0Wr;
   logic        ctlLane1Wr;
   logic        miscAnyWr;

   // Access timing at a glance:
   //   edge N   : strobe, address, byte enables and data are sampled
   //   edge N   : writes land; wake status, enable and pin update together
   //   edge N   : the read answer loads and stands for exactly one cycle
   // A read and a write in the same cycle return the value before the write.
   // Writes to read-only bits, the extension and unmapped dwords are dropped;
   // this strobe interface has no error response, so a host cannot tell.
   // Hot reset leaves every field alone: the control/status half must survive
   // the internal reset raised on leaving the hot powered-off state.
   // Wake status and enable live in their own module so the sticky enable can
   // ride across the ordinary reset without touching the rest of this state.

   // Elaboration checks: every field must sit inside the byte lane that carries it
   if (pmcfg_pkg::WAKE_STATUS_BIT < 8 || pmcfg_pkg::WAKE_STATUS_BIT > 15) begin : g_chk_sts
      $error("wake status bit must sit in control/status lane 1");
   end
   if (pmcfg_pkg::WAKE_ENABLE_BIT < 8 || pmcfg_pkg::WAKE_ENABLE_BIT > 15) begin : g_chk_en
      $error("wake enable bit must sit in control/status lane 1");
   end
   if (pmcfg_pkg::WAKE_STATUS_BIT == pmcfg_pkg::WAKE_ENABLE_BIT) begin : g_chk_wsame
      $error("wake status and enable cannot share a bit");
   end
   if (pmcfg_pkg::PSTATE_LSB > 6) begin : g_chk_ps
      $error("power state field must sit in control/status lane 0");
   end
   if (pmcfg_pkg::DYN_INFO_BIT > 7) begin : g_chk_dyn
      $error("dynamic info bit must sit in control/status lane 0");
   end
   if (pmcfg_pkg::DYN_INFO_BIT >= pmcfg_pkg::PSTATE_LSB &&
       pmcfg_pkg::DYN_INFO_BIT <= pmcfg_pkg::PSTATE_LSB + 1) begin : g_chk_dovl
      $error("dynamic info bit overlaps the power state field");
   end
   // Decode compares dwords only, so both blocks must start on a dword boundary
   if (pmcfg_pkg::PM_DWORD_OFFSET[1:0] != 2'h0) begin : g_chk_pmal
      $error("power-management dword offset is not aligned");
   end
   if (pmcfg_pkg::MISC_OFFSET[1:0] != 2'h0) begin : g_chk_mial
      $error("misc offset is not dword aligned");
   end
   if (pmcfg_pkg::CTLSTS_OFFSET != pmcfg_pkg::PM_DWORD_OFFSET) begin : g_chk_cs
      $error("control/status must open the power-management dword");
   end
   if (pmcfg_pkg::PMEXT_OFFSET[7:2] != pmcfg_pkg::PM_DWORD_OFFSET[7:2]) begin : g_chk_ext
      $error("extension must share the control/status dword");
   end
   if (pmcfg_pkg::MISC_OFFSET[7:2] == pmcfg_pkg::PM_DWORD_OFFSET[7:2]) begin : g_chk_ovl
      $error("misc and power-management dwords overlap");
   end
   // The two extension bytes and the whole-register constant must agree
   if ({pmcfg_pkg::PM_INFO_BYTE, pmcfg_pkg::BRIDGE_EXT_BYTE} != pmcfg_pkg::PMEXT_VALUE) begin : g_chk_xv
      $error("extension byte constants disagree with the register value");
   end
   // Status, power state and (without COLD_WAKE) enable come out of reset low, so the view must reset to zero
   if (pmcfg_pkg::CTLSTS_RESET != 16'h0000) begin : g_chk_csr
      $error("control/status reset view must be all zero");
   end
   // A reset bit outside the write mask could never be changed back
   if ((pmcfg_pkg::MISC_RESET & ~pmcfg_pkg::MISC_WRITE_MASK) != 32'h0000_0000) begin : g_chk_mrst
      $error("misc reset value sets a read-only bit");
   end
   if (pmcfg_pkg::MISC_WRITE_MASK[31:16] != 16'h0000) begin : g_chk_mup
      $error("misc upper half must stay read-only");
   end

   // Dword decode: control/status and extension share dword 48h
   always_comb begin
      pmHit   = 1'b0;
      miscHit = 1'b0;
      if (cfgAddr[7:2] == pmcfg_pkg::PM_DWORD_OFFSET[7:2]) begin
         pmHit = 1'b1;
      end else if (cfgAddr[7:2] == pmcfg_pkg::MISC_OFFSET[7:2]) begin
         miscHit = 1'b1;
      end
   end

   assign enAllowed = (wakeCaps != pmcfg_pkg::WAKE_CAPS_NONE);
   assign enWrite   = ctlLane1Wr;
   assign stsClear  = ctlLane1Wr & cfgWrData[pmcfg_pkg::WAKE_STATUS_BIT];

   // Control/status lane strobes; lane 0 carries the state, lane 1 the wake bits
   assign ctlLane0Wr = cfgWrite & pmHit & cfgByteEn[0];
   assign ctlLane1Wr = cfgWrite & pmHit & cfgByteEn[1];

   // Misc byte-lane write strobes, one per enabled lane
   for (genvar l = 0; l < 4; l++) begin : g_misc_lane
      assign miscLaneWr[l] = cfgWrite & miscHit & cfgByteEn[l];
   end
   assign miscAnyWr = |miscLaneWr;

   pmcfg_wake_ctl #(
      .COLD_WAKE (COLD_WAKE)
   ) u_wake (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .hotReset   (hotReset),
      .wakeEvent  (wakeEvent),
      .enWrite    (enWrite),
      .enData     (cfgWrData[pmcfg_pkg::WAKE_ENABLE_BIT]),
      .stsClear   (stsClear),
      .enAllowed  (enAllowed),
      .wakeStatus (wakeStatus),
      .wakeEnable (wakeEnable),
      .wakeOut    (wakeOut)
   );

   // Control/status read view; reserved and dynamic bits are constant zero
   always_comb begin
      ctlStsView = pmcfg_pkg::CTLSTS_RESET;
      ctlStsView[pmcfg_pkg::DYN_INFO_BIT] = 1'b0;
      ctlStsView[pmcfg_pkg::WAKE_STATUS_BIT] = wakeStatus;
      ctlStsView[pmcfg_pkg::WAKE_ENABLE_BIT] = wakeEnable;
      ctlStsView[pmcfg_pkg::PSTATE_LSB +: 2] = st_q.pstate;
   end

   // Extension half is constant; writes to lanes 2 and 3 go nowhere
   always_comb begin
      extView = {pmcfg_pkg::PM_INFO_BYTE, pmcfg_pkg::BRIDGE_EXT_BYTE};
   end

   assign pmDword = {extView, ctlStsView};   // Extension sits in the upper half

   // Per-bit misc merge; read-only bits are never loaded, so they keep their reset zero
   // masked misc write
   for (genvar b = 0; b < 32; b++) begin : g_misc_bit
      if (pmcfg_pkg::MISC_WRITE_MASK[b]) begin : g_rw
         assign miscWrite[b] = miscLaneWr[b / 8] ? cfgWrData[b] : st_q.misc[b];
      end else begin : g_ro
         assign miscWrite[b] = st_q.misc[b];
      end
   end

   // Requested power state; only the three supported codes are taken
   always_comb begin
      newState    = st_q.pstate;
      pstateLegal = 1'b0;
      case (cfgWrData[pmcfg_pkg::PSTATE_LSB +: 2])
         pmcfg_pkg::PMCFG_D0: begin
            newState    = pmcfg_pkg::PMCFG_D0;
            pstateLegal = 1'b1;
         end
         pmcfg_pkg::PMCFG_D2: begin
            newState    = pmcfg_pkg::PMCFG_D2;
            pstateLegal = 1'b1;
         end
         pmcfg_pkg::PMCFG_D3HOT: begin
            newState    = pmcfg_pkg::PMCFG_D3HOT;
            pstateLegal = 1'b1;
         end
         default: begin
            newState    = st_q.pstate;   // Unsupported code keeps the current state
            pstateLegal = 1'b0;
         end
      endcase
   end

   // Read word select by dword; unmapped dwords read zero
   always_comb begin
      rdWord = 32'h0000_0000;
      if (pmHit) begin
         rdWord = pmDword;
      end else if (miscHit) begin
         rdWord = st_q.misc;
      end
   end

   // Register next state; read data is zero outside the answer cycle
   always_comb begin
      st_d         = st_q;
      st_d.rdValid = cfgRead;
      st_d.rdData  = 32'h0000_0000;
      if (ctlLane0Wr && pstateLegal) begin
         st_d.pstate = newState;
      end
      if (miscAnyWr) begin
         st_d.misc = miscWrite;
      end
      // A write in the same cycle lands after the read word was chosen
      if (cfgRead) begin
         st_d.rdData = rdWord;
      end
   end

   // Synchronous reset; hot reset deliberately not used for power state
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q.rdData  <= 32'h0000_0000;
         st_q.rdValid <= 1'b0;
         st_q.pstate  <= pmcfg_pkg::PMCFG_D0;
         st_q.misc    <= pmcfg_pkg::MISC_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Every output comes straight from a flip-flop; the wake pin from the wake module
   assign cfgRdData  = st_q.rdData;
   assign cfgRdValid = st_q.rdValid;
   assign powerState = st_q.pstate;
   assign miscConfig = st_q.misc;
endmodule // pmcfg_regs

//--- dv/pmcfg_regs_checker.sv
// Port assertions for the power-management config registers
`timescale 1ns/1ps
module pmcfg_regs_checker (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        cfgRead,
   input wire logic        cfgWrite,
   input wire logic [7:0]  cfgAddr,
   input wire logic [3:0]  cfgByteEn,
   input wire logic [31:0] cfgWrData,
   input wire logic        wakeEvent,
   input wire logic [31:0] cfgRdData,
   input wire logic        cfgRdValid,
   input wire logic [1:0]  powerState,
   input wire logic [31:0] miscConfig,
   input wire logic        wakeOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Control/status write, then its wake-clear flavour
   sequence pmWr_s; cfgWrite && cfgAddr[7:2] == 6'h12; endsequence
   sequence wakeClr_s; pmWr_s ##0 cfgByteEn[1] && cfgWrData[15] && !wakeEvent; endsequence
   read_answer_a: assert property (cfgRead |=> cfgRdValid)
      else $error("read not answered");
   rsvd_zero_a: assert property (
      cfgRdValid && $past(cfgAddr) inside {[8'h48:8'h4B]} |-> (cfgRdData & 32'h7EFC) == 0)
      else $error("reserved bits set");
   ext_zero_a: assert property (
      cfgRdValid && $past(cfgAddr) inside {[8'h48:8'h4B]} |-> cfgRdData[31:16] == 16'h0)
      else $error("extension not zero");
   pstate_write_a: assert property (
      pmWr_s ##0 cfgByteEn[0] && cfgWrData[1:0] != 2'h1 |=> powerState == $past(cfgWrData[1:0]))
      else $error("power state not taken");
   pstate_legal_a: assert property (powerState != 2'h1)
      else $error("unsupported power state");
   misc_ro_a: assert property ((miscConfig & 32'hFFFF_5BE0) == 0)
      else $error("misc read-only bit set");
   misc_reset_a: assert property ($past(srst) |-> miscConfig == 32'h0000_2400)
      else $error("misc reset value");
   wake_clear_a: assert property (wakeClr_s |=> !wakeOut)
      else $error("wake not cleared");
endmodule // pmcfg_regs_checker
bind pmcfg_regs pmcfg_regs_checker i_chk (.sys_clk, .srst, .cfgRead, .cfgWrite, .cfgAddr,
   .cfgByteEn, .cfgWrData, .wakeEvent, .cfgRdData, .cfgRdValid, .powerState, .miscConfig,
   .wakeOut);

//--- dv/pmcfg_host_model.sv
// Host model issuing configuration read and write cycles
`timescale 1ns/1ps
module pmcfg_host_model (
   input  wire logic   sys_clk,
   output logic        cfgRead,
   output logic        cfgWrite,
   output logic [7:0]  cfgAddr,
   output logic [3:0]  cfgByteEn,
   output logic [31:0] cfgWrData
);
   initial {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = '0;
   // One strobe cycle off the falling edge; on release address and data invert so stale values never match
   task automatic cyc(input logic rd, input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d);
      @(negedge sys_clk);
      {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {rd, !rd, a, b, d};
      @(negedge sys_clk);
      {cfgRead, cfgWrite, cfgAddr, cfgWrData} = {2'b00, ~a, ~d};
   endtask
   task automatic osLoad();
      cyc(1'b0, 8'h48, 4'h2, 32'h0);
   endtask
endmodule // pmcfg_host_model

//--- dv/tb.sv
// Self-checking bench for the power-management config registers
`timescale 1ns/1ps
module tb;
   logic        sys_clk = 0, srst = 1, hotReset = 0, wakeEvent = 0;
   logic [4:0]  wakeCaps = 5'h1F;
   logic        cfgRead, cfgWrite, cfgRdValid, wakeOut;
   logic [7:0]  cfgAddr;
   logic [3:0]  cfgByteEn, be;
   logic [31:0] cfgWrData, cfgRdData, miscConfig, misc, d, m;
   logic [1:0]  powerState, ps;
   logic [31:0] expQ[$];
   int          error_cnt = 0, tests_run = 0, seed = 68318;
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   pmcfg_regs #(.COLD_WAKE(1'b0)) i_dut (.sys_clk, .srst, .hotReset, .cfgRead, .cfgWrite,
      .cfgAddr, .cfgByteEn, .cfgWrData, .wakeEvent, .wakeCaps, .cfgRdData, .cfgRdValid,
      .powerState, .miscConfig, .wakeOut);
   pmcfg_host_model i_host (.sys_clk, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData);
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      i_host.cyc(1'b1, a, 4'hF, 32'h0);
   endtask
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Answers are matched against the oldest note, mid-cycle, clear of the launching edge
   always @(negedge sys_clk) begin
      if (cfgRdValid === 1'b1)
         check("read data", cfgRdData, expQ.size() ? expQ.pop_front() : 32'hDEAD);
   end
   // Watchdog, far beyond the roughly 70 cycles needed
   initial begin
      #(3000 * 50);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      srst = 0;
      i_host.osLoad();
      rd(8'hF0, 32'h0000_2400);
      misc = 32'h0000_2400;
      repeat (6) begin
         d = $random(seed);
         be = $random(seed);
         for (int i = 0; i < 4; i++) m[8*i+:8] = {8{be[i]}};
         m = m & 32'h0000_A41F;
         misc = (misc & ~m) | (d & m);
         i_host.cyc(1'b0, 8'hF0, be, d);
         check("misc", miscConfig, misc);
      end
      ps = 2'h0;
      for (int v = 0; v < 4; v++) begin
         d = ($random(seed) & 32'hFFFF_7EFC) | 32'(v);
         i_host.cyc(1'b0, 8'h48, 4'hF, d);
         if (v != 1) ps = 2'(v);
         check("power state", powerState, ps);
         rd(8'h4A, {30'h0, ps});
      end
      hotReset = 1;
      @(negedge sys_clk);
      hotReset = 0;
      check("hot reset", powerState, 2'h3);
      i_host.cyc(1'b0, 8'h48, 4'h3, 32'h0);
      wakeEvent = 1;
      @(negedge sys_clk);
      wakeEvent = 0;
      repeat (2) @(negedge sys_clk);
      check("wake gated", wakeOut, 0);
      rd(8'h48, 32'h8000);
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h0100);
      @(negedge sys_clk);
      check("wake out", wakeOut, 1);
      // Event held through the clear write: the set must win
      wakeEvent = 1;
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h8100);
      wakeEvent = 0;
      check("set beats clear", wakeOut, 1);
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h8100);
      @(negedge sys_clk);
      check("wake clear", wakeOut, 0);
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h0);
      wakeCaps = 5'h00;
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h0100);
      rd(8'h48, 32'h0);
      wakeCaps = 5'h1F;
      i_host.cyc(1'b0, 8'h48, 4'h2, 32'h0100);
      srst = 1;
      repeat (2) @(negedge sys_clk);
      srst = 0;
      rd(8'h48, 32'h0);
      repeat (3) @(negedge sys_clk);
      check("notes left", expQ.size(), 0);
      finish_test();
   end
endmodule // tb
